// *** timer_cfg.svh ***
// Register indices, field positions, reset values and timing figures
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define IDX_MODE 8'h2a
`define IDX_PRESCALE_LO 8'h2b
`define IDX_PRESET_HI 8'h2c
`define IDX_PRESET_LO 8'h2d
`define IDX_CURRENT_HI 8'h2e
`define IDX_CURRENT_LO 8'h2f
`define IDX_AUX_CTRL 8'h38
`define IDX_STATUS 8'h39
`define IDX_IRQ_STATUS 8'h3a
`define IDX_IRQ_MASK 8'h3b
`define MODE_AUTO_BIT 7
`define MODE_GATE_HI 6
`define MODE_GATE_LO 5
`define MODE_RELOAD_BIT 4
`define MODE_NIBBLE_HI 3
`define MODE_NIBBLE_LO 0
`define CTRL_MULTI_BIT 0
`define CTRL_START_BIT 1
`define CTRL_HALT_BIT 2
`define IRQ_DONE_BIT 0
`define IRQ_WRAP_BIT 1
`define IRQ_W 2
`define RST_BYTE 8'h00
`define GATE_NONE 2'h0
`define GATE_MULTIFUNCTION_INPUT_PIN 2'h1
`define GATE_AUXILIARY_PIN_ONE 2'h2
`define GATE_ANA3 2'h3
`define REF_KHZ 18'h01a7c
`define CLK_KHZ 18'h30d40
`endif

// *** timer_pkg.sv ***
// State types of the protocol countdown timer
package timer_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

  typedef struct packed {
    run_state_t st;
    logic [7:0] mode;
    logic [7:0] prescale_lo;
    logic [7:0] preset_hi;
    logic [7:0] preset_lo;
    logic [15:0] cnt;
    logic multi;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] prdata;
  } timer_state_t;

  typedef struct packed {
    logic [17:0] acc;
    logic pulse;
  } ref_state_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic tick;
  } presc_state_t;
endpackage : timer_pkg

// *** ref_clock_enable.sv ***
// Fractional divider giving a 6.78 MHz enable pulse from pclk
`include "timer_cfg.svh"
module ref_clock_enable (
  input wire logic pclk,
  input wire logic presetn,
  output logic ref_en
);
  timer_pkg::ref_state_t s_q;
  timer_pkg::ref_state_t s_d;
  logic [17:0] sum;

  // Phase accumulator keeps the long-term rate exact; jitter is one cycle
  always_comb begin
    s_d = s_q;
    sum = s_q.acc + `REF_KHZ;
    if (sum >= `CLK_KHZ) begin // R10
      s_d.acc = sum - `CLK_KHZ;
      s_d.pulse = 1'b1;
    end else begin
      s_d.acc = sum;
      s_d.pulse = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ref_en = s_q.pulse;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ref_gap;
    ref_en |=> !ref_en ##1 !ref_en ##1 !ref_en;
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("ref too fast"); // R10
endmodule : ref_clock_enable

// *** tick_prescaler.sv ***
// Divides the reference enable by the 12-bit divisor into timer ticks
module tick_prescaler #(
  parameter int DIV_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ref_en,
  input wire logic restart,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);
  timer_pkg::presc_state_t s_q;
  timer_pkg::presc_state_t s_d;
  logic [DIV_W-1:0] last;

  // A divisor of zero has no meaning; it runs as divide by one
  assign last = (divisor == '0) ? '0 : divisor - 1'b1;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart) begin
      s_d.cnt = '0;
    end else if (ref_en) begin
      if (s_q.cnt >= last) begin // R10
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tick_wrap;
    tick |-> s_q.cnt == '0;
  endproperty
  a_tick_wrap: assert property (p_tick_wrap) else $error("tick off"); // R10
endmodule : tick_prescaler

// *** protocol_countdown_timer.sv ***
// Protocol countdown timer with APB registers and interrupt
//
// Functional notes
// R1 - Auto-start bit 7 set: transmission end starts timer, every mode and speed.
// R2 - Auto-start with multi-frame clear: first received bit stops timer.
// R3 - Auto-start with multi-frame set: only the halt bit stops timer.
// R4 - Auto-start clear: transmit and receive events never start or stop timer.
// R5 - Bits 6:5 select gate: none, multifunction, auxiliary one, analog three.
// R6 - In gated mode active flag shows register enable, ignoring gate pin.
// R7 - Reload-on-zero bit 4 set: count restarts from preset at zero.
// R8 - Reload-on-zero clear: count ends at zero and sets done flag.
// R9 - Divisor is mode bits 3:0 above the prescale low byte.
// R10 - Tick rate is 6.78 MHz divided by the divisor.
// R11 - Mode and prescale low are read-write and reset to 00h.
// R12 - Each start loads the preset; preset writes act at next start.
// R13 - Current count readable as high and low read-only bytes.
// R14 - Running and gate open: count drops by one per tick.
`include "timer_cfg.svh"
module protocol_countdown_timer #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_end,
  input wire logic rx_first_bit,
  input wire logic multifunction_input_pin,
  input wire logic auxiliary_pin_one,
  input wire logic analog_pin_three,
  output logic timer_active_flag,
  output logic countdown_done_flag,
  output logic irq
);
  timer_pkg::timer_state_t s_q;
  timer_pkg::timer_state_t s_d;

  logic [7:0] idx;
  logic addr_ok;
  logic mapped;
  logic wr;
  logic [31:0] rd_val;
  logic protocol_auto_start;
  logic [1:0] gate_source_select;
  logic reload_on_zero;
  logic [11:0] prescale_divisor;
  logic [15:0] countdown_preset;
  logic sw_start;
  logic immediate_timer_halt;
  logic start_evt;
  logic stop_evt;
  logic gate_open;
  logic ref_en;
  logic tick;
  logic running;
  logic tick_ok;
  logic done_evt;
  logic wrap_evt;
  logic [`IRQ_W-1:0] irq_clr;

  // Register bus decode
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  always_comb begin
    case (idx)
      `IDX_MODE, `IDX_PRESCALE_LO, `IDX_PRESET_HI, `IDX_PRESET_LO,
      `IDX_CURRENT_HI, `IDX_CURRENT_LO, `IDX_AUX_CTRL, `IDX_STATUS,
      `IDX_IRQ_STATUS, `IDX_IRQ_MASK: mapped = addr_ok;
      default: mapped = 1'b0;
    endcase
  end
  // Zero wait states; read data is captured in the setup cycle, writes act in the access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr = psel && penable && pwrite && mapped;
  assign prdata = s_q.prdata;

  // Mode fields
  assign protocol_auto_start = s_q.mode[`MODE_AUTO_BIT];
  assign gate_source_select = s_q.mode[`MODE_GATE_HI:`MODE_GATE_LO];
  assign reload_on_zero = s_q.mode[`MODE_RELOAD_BIT];
  assign prescale_divisor = {s_q.mode[`MODE_NIBBLE_HI:`MODE_NIBBLE_LO],
                             s_q.prescale_lo}; // R9
  assign countdown_preset = {s_q.preset_hi, s_q.preset_lo};

  // Software command strobes
  assign sw_start = wr && (idx == `IDX_AUX_CTRL) && pwdata[`CTRL_START_BIT];
  assign immediate_timer_halt = wr && (idx == `IDX_AUX_CTRL)
                                && pwdata[`CTRL_HALT_BIT]; // R3
  assign irq_clr = (wr && (idx == `IDX_IRQ_STATUS)) ?
                   pwdata[`IRQ_W-1:0] : '0;

  // Protocol events only count while auto-start is set
  assign start_evt = (protocol_auto_start && tx_end) || sw_start; // R1 R4
  // With multi-frame receive set, reception leaves the timer alone
  assign stop_evt = (protocol_auto_start && !s_q.multi && rx_first_bit)
                    || immediate_timer_halt; // R2 R3 R4

  // Gate selection
  always_comb begin
    case (gate_source_select) // R5
      `GATE_NONE: gate_open = 1'b1;
      `GATE_MULTIFUNCTION_INPUT_PIN: gate_open = multifunction_input_pin;
      `GATE_AUXILIARY_PIN_ONE: gate_open = auxiliary_pin_one;
      `GATE_ANA3: gate_open = analog_pin_three;
      default: gate_open = 1'b1;
    endcase
  end

  assign running = (s_q.st == timer_pkg::ST_RUN);
  // Active flag follows the register enable only, never the gate pin
  assign timer_active_flag = running; // R6
  assign tick_ok = running && tick && gate_open && !start_evt && !stop_evt;

  // Read mux
  always_comb begin
    rd_val = '0;
    case (idx)
      `IDX_MODE: rd_val[7:0] = s_q.mode;
      `IDX_PRESCALE_LO: rd_val[7:0] = s_q.prescale_lo;
      `IDX_PRESET_HI: rd_val[7:0] = s_q.preset_hi;
      `IDX_PRESET_LO: rd_val[7:0] = s_q.preset_lo;
      `IDX_CURRENT_HI: rd_val[7:0] = s_q.cnt[15:8]; // R13
      `IDX_CURRENT_LO: rd_val[7:0] = s_q.cnt[7:0]; // R13
      `IDX_AUX_CTRL: rd_val[`CTRL_MULTI_BIT] = s_q.multi;
      `IDX_STATUS: rd_val[0] = running;
      `IDX_IRQ_STATUS: rd_val[`IRQ_W-1:0] = s_q.irq_stat;
      `IDX_IRQ_MASK: rd_val[`IRQ_W-1:0] = s_q.irq_mask;
      default: rd_val = '0;
    endcase
    if (!addr_ok) begin
      rd_val = '0;
    end
  end

  // Next state
  always_comb begin
    s_d = s_q;
    done_evt = 1'b0;
    wrap_evt = 1'b0;
    if (psel && !penable && !pwrite) begin
      s_d.prdata = rd_val;
    end
    if (wr) begin
      case (idx)
        `IDX_MODE: s_d.mode = pwdata[7:0]; // R11
        `IDX_PRESCALE_LO: s_d.prescale_lo = pwdata[7:0]; // R11
        `IDX_PRESET_HI: s_d.preset_hi = pwdata[7:0];
        `IDX_PRESET_LO: s_d.preset_lo = pwdata[7:0];
        `IDX_AUX_CTRL: s_d.multi = pwdata[`CTRL_MULTI_BIT];
        `IDX_IRQ_MASK: s_d.irq_mask = pwdata[`IRQ_W-1:0];
        default: s_d.multi = s_q.multi;
      endcase
    end
    case (s_q.st)
      timer_pkg::ST_IDLE: begin
        // A stop in the same cycle as a start wins
        if (start_evt && !stop_evt) begin
          s_d.st = timer_pkg::ST_RUN;
          s_d.cnt = countdown_preset; // R12
        end
      end
      timer_pkg::ST_RUN: begin
        if (stop_evt) begin
          s_d.st = timer_pkg::ST_IDLE; // R2 R3
        end else if (start_evt) begin
          s_d.cnt = countdown_preset; // R12
        end else if (tick_ok) begin
          if (s_q.cnt == 16'h0000 && reload_on_zero) begin
            s_d.cnt = countdown_preset; // R7
            wrap_evt = 1'b1;
          end else begin
            if (s_q.cnt != 16'h0000) begin
              s_d.cnt = s_q.cnt - 16'h0001; // R14
            end
            if (s_q.cnt <= 16'h0001) begin
              done_evt = 1'b1; // R8
              if (!reload_on_zero) begin
                s_d.st = timer_pkg::ST_IDLE; // R8
              end
            end
          end
        end
      end
      default: s_d.st = timer_pkg::ST_IDLE;
    endcase
    // An event in the clearing cycle survives the clear
    s_d.irq_stat = (s_q.irq_stat & ~irq_clr)
                   | {wrap_evt, done_evt}; // R8
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= timer_pkg::ST_IDLE;
      s_q.mode <= `RST_BYTE;
      s_q.prescale_lo <= `RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  assign countdown_done_flag = s_q.irq_stat[`IRQ_DONE_BIT];
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  ref_clock_enable u_ref (
    .pclk(pclk),
    .presetn(presetn),
    .ref_en(ref_en)
  );

  tick_prescaler #(
    .DIV_W(12)
  ) u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .ref_en(ref_en),
    .restart(start_evt),
    .divisor(prescale_divisor),
    .tick(tick)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_auto_start;
    !running && protocol_auto_start && tx_end && !stop_evt |=> running;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("no start"); // R1

  property p_rx_stop;
    running && protocol_auto_start && !s_q.multi && rx_first_bit
    |=> !running ##1 !running || $past(start_evt);
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("no rx stop"); // R2

  property p_multi_keep;
    running && s_q.multi && rx_first_bit && !immediate_timer_halt
    && !tick_ok |=> running;
  endproperty
  a_multi_keep: assert property (p_multi_keep) else $error("rx stop"); // R3

  property p_no_auto;
    !running && !protocol_auto_start && !sw_start |=> !running;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("protocol start"); // R4

  property p_gate_hold;
    running && !gate_open && !start_evt |=> $stable(s_q.cnt);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate leak"); // R5

  property p_active_gated;
    running && gate_source_select != `GATE_NONE && !gate_open
    |-> timer_active_flag;
  endproperty
  a_active_gated: assert property (p_active_gated) else $error("flag"); // R6

  property p_reload;
    tick_ok && s_q.cnt == 16'h0000 && reload_on_zero
    |=> running && s_q.cnt == $past(countdown_preset);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload"); // R7

  property p_done;
    tick_ok && s_q.cnt == 16'h0001 && !reload_on_zero
    |=> !running && countdown_done_flag && s_q.cnt == 16'h0000;
  endproperty
  a_done: assert property (p_done) else $error("no done"); // R8

  property p_start_load;
    start_evt && !stop_evt |=> s_q.cnt == $past(countdown_preset);
  endproperty
  a_start_load: assert property (p_start_load) else $error("no load"); // R12

  property p_decrement;
    tick_ok && s_q.cnt > 16'h0001 |=> s_q.cnt == $past(s_q.cnt) - 16'h0001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("no dec"); // R14
endmodule : protocol_countdown_timer

// *** tb_protocol_countdown_timer.sv ***
// Self-checking bench of the protocol countdown timer over APB
`include "timer_cfg.svh"
module tb_protocol_countdown_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic tx_end, rx_first_bit, active, done, irq;
  logic [2:0] gate_pins;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  protocol_countdown_timer DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_end(tx_end),
    .rx_first_bit(rx_first_bit),
    .multifunction_input_pin(gate_pins[0]),
    .auxiliary_pin_one(gate_pins[1]), .analog_pin_three(gate_pins[2]),
    .timer_active_flag(active), .countdown_done_flag(done), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Hang guard: the slowest test needs about 15100 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the hang guard ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask : rdc

  // Events act one edge after they are taken; two edges leave margin
  task automatic flag(input logic exp);
    repeat (2) @(posedge pclk);
    chk({31'h0, active}, {31'h0, exp});
  endtask : flag

  task automatic pulse(input logic [1:0] ev);
    @(posedge pclk);
    tx_end <= ev[0];
    rx_first_bit <= ev[1];
    @(posedge pclk);
    tx_end <= 1'b0;
    rx_first_bit <= 1'b0;
  endtask : pulse

  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while (done !== 1'b1 && k < lim) begin
      @(posedge pclk);
      k++;
    end
    chk({31'h0, done}, 32'h1);
  endtask : wait_done

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_end = 1'b0;
    rx_first_bit = 1'b0;
    gate_pins = 3'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`IDX_MODE, 8'h00);
    rdc(`IDX_PRESCALE_LO, 8'h00);
    apb(1'b1, `IDX_MODE, 8'h0f);
    rdc(`IDX_MODE, 8'h0f);
    chk({31'h0, err}, 32'h0);
    apb(1'b1, `IDX_PRESCALE_LO, 8'ha5);
    rdc(`IDX_PRESCALE_LO, 8'ha5);
    apb(1'b1, `IDX_CURRENT_LO, 8'h55);
    rdc(`IDX_CURRENT_LO, 8'h00);
    rdc(8'h10, 8'h00);
    chk({31'h0, err}, 32'h1);
    $display("test registers done");
    // Slow ticks so the count stays put while it is read
    apb(1'b1, `IDX_MODE, 8'h00);
    apb(1'b1, `IDX_PRESCALE_LO, 8'hff);
    apb(1'b1, `IDX_PRESET_HI, 8'h00);
    apb(1'b1, `IDX_PRESET_LO, 8'h10);
    pulse(2'b01);
    flag(1'b0);
    apb(1'b1, `IDX_AUX_CTRL, 8'h02);
    pulse(2'b10);
    flag(1'b1);
    apb(1'b1, `IDX_AUX_CTRL, 8'h04);
    flag(1'b0);
    $display("test protocol off done");
    apb(1'b1, `IDX_MODE, 8'h80);
    pulse(2'b01);
    flag(1'b1);
    rdc(`IDX_STATUS, 8'h01);
    rdc(`IDX_CURRENT_LO, 8'h10);
    apb(1'b1, `IDX_PRESET_LO, 8'h20);
    rdc(`IDX_PRESET_LO, 8'h20);
    rdc(`IDX_CURRENT_LO, 8'h10);
    rdc(`IDX_CURRENT_HI, 8'h00);
    pulse(2'b10);
    flag(1'b0);
    apb(1'b1, `IDX_AUX_CTRL, 8'h01);
    rdc(`IDX_AUX_CTRL, 8'h01);
    pulse(2'b01);
    flag(1'b1);
    pulse(2'b10);
    flag(1'b1);
    apb(1'b1, `IDX_AUX_CTRL, 8'h05);
    flag(1'b0);
    apb(1'b1, `IDX_AUX_CTRL, 8'h00);
    $display("test protocol on done");
    apb(1'b1, `IDX_MODE, 8'h00);
    apb(1'b1, `IDX_PRESCALE_LO, 8'h01);
    apb(1'b1, `IDX_PRESET_LO, 8'h03);
    apb(1'b1, `IDX_IRQ_MASK, 8'h01);
    apb(1'b1, `IDX_AUX_CTRL, 8'h02);
    wait_done(200);
    flag(1'b0);
    chk({31'h0, irq}, 32'h1);
    rdc(`IDX_CURRENT_LO, 8'h00);
    rdc(`IDX_STATUS, 8'h00);
    apb(1'b1, `IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("test one shot done");
    apb(1'b1, `IDX_MODE, 8'h10);
    apb(1'b1, `IDX_IRQ_MASK, 8'h00);
    apb(1'b1, `IDX_PRESET_LO, 8'h02);
    apb(1'b1, `IDX_AUX_CTRL, 8'h02);
    n = 0;
    do begin
      apb(1'b0, `IDX_IRQ_STATUS, 8'h00);
      n++;
    end while (rd[`IRQ_WRAP_BIT] !== 1'b1 && n < 100);
    chk({31'h0, rd[`IRQ_WRAP_BIT]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    flag(1'b1);
    apb(1'b1, `IDX_IRQ_MASK, 8'h02);
    rdc(`IDX_IRQ_MASK, 8'h02);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `IDX_AUX_CTRL, 8'h04);
    apb(1'b1, `IDX_IRQ_STATUS, 8'h03);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("test reload done");
    // Only the selected pin may open the gate; the others are held high while it is low
    for (int g = 1; g < 4; g++) begin
      apb(1'b1, `IDX_MODE, 8'(g << 5));
      apb(1'b1, `IDX_PRESET_LO, 8'h05);
      gate_pins <= ~(3'h1 << (g - 1));
      apb(1'b1, `IDX_AUX_CTRL, 8'h02);
      repeat (200) @(posedge pclk);
      rdc(`IDX_CURRENT_LO, 8'h05);
      flag(1'b1);
      gate_pins <= 3'h1 << (g - 1);
      wait_done(400);
      apb(1'b1, `IDX_IRQ_STATUS, 8'h01);
      gate_pins <= 3'h0;
    end
    $display("test gating done");
    // Divisor 256 from the upper nibble: two ticks take about 15100 cycles
    apb(1'b1, `IDX_MODE, 8'h01);
    apb(1'b1, `IDX_PRESCALE_LO, 8'h00);
    apb(1'b1, `IDX_PRESET_LO, 8'h02);
    apb(1'b1, `IDX_AUX_CTRL, 8'h02);
    repeat (13000) @(posedge pclk);
    flag(1'b1);
    chk({31'h0, done}, 32'h0);
    wait_done(4000);
    $display("test divisor done");
    give_verdict();
  end
endmodule : tb_protocol_countdown_timer
